// File: src/illegal_opcode_classifier.sv
// classifies each fetched instruction word as execute, reserved or
// coprocessor-unusable, from software-loaded markings and configuration
// assumes fetch words are synchronous to pclk and APB is a plain slave port
//
// Overview of operation
// - reserved markings raise reserved-instruction exception
// - coprocessor-unusable beats reserved in coprocessor space
// - release 6 traps every empty encoding
// - class markings decode further via sub-table
// - higher-level or newer encodings raise reserved
// - 64-bit-only encodings execute when 64-bit enabled
// - release 1: 64-bit float needs 64-bit ops
// - release 2: 64-bit float needs float64 enable
// - release 1: corrected float legal only 64-bit
// - release 2 on: corrected float always legal
// - unused custom encodings: reserved or unusable
`timescale 1ns/100ps
module illegal_opcode_classifier (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_word,
    output logic             dec_valid,
    output logic [31:0]      dec_word,
    output logic             dec_exec,
    output logic             dec_ri,
    output logic             dec_cpu,
    output logic [1:0]       dec_cop_num,
    output logic             irq
);
    lookup_if lk ();

    logic [11:0] ctrl_reg;
    logic [11:0] ctrl_next;
    logic [8:0]  taddr_reg;
    logic [8:0]  taddr_next;
    logic [31:0] fword_reg;
    logic [31:0] fword_next;
    logic [4:0]  finfo_reg;
    logic [4:0]  finfo_next;
    logic [15:0] ri_cnt_reg;
    logic [15:0] ri_cnt_next;
    logic [15:0] cpu_cnt_reg;
    logic [15:0] cpu_cnt_next;
    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;

    logic        dvalid_next;
    logic [31:0] dword_next;
    logic        dexec_next;
    logic        dri_next;
    logic        dcpu_next;
    logic [1:0]  dcop_next;

    logic                        acc;
    logic                        wr_fire;
    logic                        mapped;
    logic [opcls_pkg::NUM_EVT-1:0] evt_set;
    logic [opcls_pkg::NUM_EVT-1:0] evt_clr;
    logic [opcls_pkg::NUM_EVT-1:0] evt_status;
    logic [opcls_pkg::NUM_EVT-1:0] evt_enable;
    logic                        en_wr;

    logic [1:0]  rel;
    logic        ops64;
    logic        fp64;
    logic        impl64;
    logic [3:0]  cop_ok;

    opcls_pkg::entry_t   prim;
    opcls_pkg::entry_t   sub;
    opcls_pkg::outcome_t outcome;
    logic                legal;
    logic                denied;
    logic                sub_nested;

    mark_table u_table (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk.table_side)
    );

    event_irq #(
        .N (opcls_pkg::NUM_EVT)
    ) u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (evt_set),
        .clr     (evt_clr),
        .en_wr   (en_wr),
        .en_data (pwdata[opcls_pkg::NUM_EVT-1:0]),
        .status  (evt_status),
        .enable  (evt_enable),
        .irq     (irq)
    );

    assign rel    = ctrl_reg[opcls_pkg::CTRL_REL_LSB +: 2];
    assign ops64  = ctrl_reg[opcls_pkg::CTRL_OPS64];
    assign fp64   = ctrl_reg[opcls_pkg::CTRL_FP64];
    assign impl64 = ctrl_reg[opcls_pkg::CTRL_IMPL64];
    assign cop_ok = ctrl_reg[opcls_pkg::CTRL_COP_LSB +: 4];

    // legality of one marking under the active configuration
    function automatic logic mark_legal(
        input opcls_pkg::mark_t mk,
        input logic [1:0]       r,
        input logic             o64,
        input logic             f64,
        input logic             i64
    );
        logic ok;
        ok = 1'b0;
        case (mk)
            opcls_pkg::MK_IMPL:     ok = 1'b1;
            // earlier releases leave empty slots to the implementation
            opcls_pkg::MK_EMPTY:    ok = (r != opcls_pkg::REL_6);
            opcls_pkg::MK_64ONLY:   ok = o64;
            opcls_pkg::MK_FP64:     ok = (r == opcls_pkg::REL_1) ? o64 : f64;
            // fpu register mode deliberately plays no part here
            opcls_pkg::MK_CORR:     ok = (r == opcls_pkg::REL_1) ? i64 : 1'b1;
            opcls_pkg::MK_RESERVED: ok = 1'b0;
            opcls_pkg::MK_HIGHER:   ok = 1'b0;
            opcls_pkg::MK_CUSTOM:   ok = 1'b0;
            default:                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // lookup: primary by opcode, sub-table by function or rs field
    assign lk.prim_idx = fetch_word[opcls_pkg::OPC_LSB +: 6];
    assign prim        = lk.prim_entry;
    assign lk.sub_idx  = prim.sub_rs ?
                         {prim.sub_id, 1'b0, fetch_word[opcls_pkg::RS_LSB +: 5]} :
                         {prim.sub_id, fetch_word[opcls_pkg::FN_LSB +: 6]};
    assign sub         = lk.sub_entry;

    always_comb begin
        sub_nested = 1'b0;
        if (prim.mark == opcls_pkg::MK_CLASS) begin
            // a class inside a class is not decodable, so it traps
            sub_nested = (sub.mark == opcls_pkg::MK_CLASS);
            legal = mark_legal(sub.mark, rel, ops64, fp64, impl64);
        end else begin
            legal = mark_legal(prim.mark, rel, ops64, fp64, impl64);
        end
        // coprocessor space is owned by the primary entry
        denied = prim.cop_space && !cop_ok[prim.cop_num];
        if (denied)
            outcome = opcls_pkg::OUT_CPU;
        else if (!legal)
            outcome = opcls_pkg::OUT_RI;
        else
            outcome = opcls_pkg::OUT_EXEC;
    end

    // decode stage: exactly one outcome flag per valid word
    always_comb begin
        dvalid_next = fetch_valid;
        dword_next  = fetch_valid ? fetch_word : dec_word;
        dexec_next  = fetch_valid && (outcome == opcls_pkg::OUT_EXEC);
        dri_next    = fetch_valid && (outcome == opcls_pkg::OUT_RI);
        dcpu_next   = fetch_valid && (outcome == opcls_pkg::OUT_CPU);
        dcop_next   = fetch_valid ? prim.cop_num : dec_cop_num;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_valid   <= 1'b0;
            dec_word    <= '0;
            dec_exec    <= 1'b0;
            dec_ri      <= 1'b0;
            dec_cpu     <= 1'b0;
            dec_cop_num <= '0;
        end else begin
            dec_valid   <= dvalid_next;
            dec_word    <= dword_next;
            dec_exec    <= dexec_next;
            dec_ri      <= dri_next;
            dec_cpu     <= dcpu_next;
            dec_cop_num <= dcop_next;
        end
    end

    // events are taken from the decode stage so they match the outputs
    always_comb begin
        evt_set                     = '0;
        evt_set[opcls_pkg::EVT_RI]  = dri_next;
        evt_set[opcls_pkg::EVT_CPU] = dcpu_next;
        evt_set[opcls_pkg::EVT_SUB] = fetch_valid && sub_nested;
    end

    // APB: one wait state so read data leaves a flip-flop
    assign acc     = psel && penable;
    assign wr_fire = acc && pready && pwrite;

    always_comb begin
        case (paddr)
            opcls_pkg::CTRL_OFF,  opcls_pkg::STAT_OFF,
            opcls_pkg::INTCLR_OFF, opcls_pkg::INTEN_OFF,
            opcls_pkg::TADDR_OFF, opcls_pkg::TDATA_OFF,
            opcls_pkg::FWORD_OFF, opcls_pkg::FINFO_OFF,
            opcls_pkg::CNT_OFF:   mapped = 1'b1;
            default:              mapped = 1'b0;
        endcase
    end

    always_comb begin
        pready_next  = acc && !pready;
        pslverr_next = acc && !pready && !mapped;
        prdata_next  = '0;
        if (acc && !pready && !pwrite) begin
            case (paddr)
                opcls_pkg::CTRL_OFF:  prdata_next = {20'h00000, ctrl_reg};
                opcls_pkg::STAT_OFF:  prdata_next = {29'h0, evt_status};
                opcls_pkg::INTEN_OFF: prdata_next = {29'h0, evt_enable};
                opcls_pkg::TADDR_OFF: prdata_next = {23'h000000, taddr_reg};
                opcls_pkg::FWORD_OFF: prdata_next = fword_reg;
                opcls_pkg::FINFO_OFF: prdata_next = {27'h0000000, finfo_reg};
                opcls_pkg::CNT_OFF:   prdata_next = {cpu_cnt_reg, ri_cnt_reg};
                default:              prdata_next = '0;
            endcase
        end
    end

    always_comb begin
        ctrl_next  = ctrl_reg;
        taddr_next = taddr_reg;
        evt_clr    = '0;
        en_wr      = 1'b0;
        lk.wr_en    = 1'b0;
        lk.wr_sub   = taddr_reg[opcls_pkg::TSUB_BIT];
        lk.wr_addr  = taddr_reg[7:0];
        lk.wr_entry = opcls_pkg::entry_t'(pwdata[opcls_pkg::ENTRY_W-1:0]);
        if (wr_fire) begin
            case (paddr)
                opcls_pkg::CTRL_OFF:   ctrl_next = pwdata[11:0];
                opcls_pkg::INTCLR_OFF: evt_clr = pwdata[opcls_pkg::NUM_EVT-1:0];
                opcls_pkg::INTEN_OFF:  en_wr = 1'b1;
                opcls_pkg::TADDR_OFF:  taddr_next = pwdata[8:0];
                opcls_pkg::TDATA_OFF: begin
                    // auto-increment lets a table load stream without reaiming
                    lk.wr_en   = 1'b1;
                    taddr_next = taddr_reg + 9'h001;
                end
                default: ;
            endcase
        end
    end

    // fault capture and saturating counters
    always_comb begin
        fword_next   = fword_reg;
        finfo_next   = finfo_reg;
        ri_cnt_next  = ri_cnt_reg;
        cpu_cnt_next = cpu_cnt_reg;
        if (dri_next || dcpu_next) begin
            fword_next = fetch_word;
            finfo_next = {1'b1, prim.cop_num, dcpu_next, dri_next};
        end
        if (dri_next && ri_cnt_reg != 16'hFFFF)
            ri_cnt_next = ri_cnt_reg + 16'h0001;
        if (dcpu_next && cpu_cnt_reg != 16'hFFFF)
            cpu_cnt_next = cpu_cnt_reg + 16'h0001;
        // a counter write clears both; a new event that cycle is dropped
        if (wr_fire && paddr == opcls_pkg::CNT_OFF) begin
            ri_cnt_next  = '0;
            cpu_cnt_next = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= opcls_pkg::CTRL_RST;
            taddr_reg   <= '0;
            fword_reg   <= '0;
            finfo_reg   <= '0;
            ri_cnt_reg  <= '0;
            cpu_cnt_reg <= '0;
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            taddr_reg   <= taddr_next;
            fword_reg   <= fword_next;
            finfo_reg   <= finfo_next;
            ri_cnt_reg  <= ri_cnt_next;
            cpu_cnt_reg <= cpu_cnt_next;
            prdata      <= prdata_next;
            pready      <= pready_next;
            pslverr     <= pslverr_next;
        end
    end
endmodule

// File: src/opcls_pkg.sv
// constants and types shared by the opcode classifier files
// assumes a single pclk domain with an APB slave for software access
package opcls_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STAT_OFF   = 8'h04;
    localparam logic [7:0] INTCLR_OFF = 8'h08;
    localparam logic [7:0] INTEN_OFF  = 8'h0C;
    localparam logic [7:0] TADDR_OFF  = 8'h10;
    localparam logic [7:0] TDATA_OFF  = 8'h14;
    localparam logic [7:0] FWORD_OFF  = 8'h18;
    localparam logic [7:0] FINFO_OFF  = 8'h1C;
    localparam logic [7:0] CNT_OFF    = 8'h20;
    // control fields
    localparam int CTRL_REL_LSB = 0;
    localparam int CTRL_OPS64   = 2;
    localparam int CTRL_FP64    = 3;
    localparam int CTRL_IMPL64  = 4;
    localparam int CTRL_FRM     = 5;
    localparam int CTRL_COP_LSB = 8;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [1:0] REL_1 = 2'h0;
    localparam logic [1:0] REL_2 = 2'h1;
    localparam logic [1:0] REL_6 = 2'h2;
    // status events
    localparam int NUM_EVT = 3;
    localparam int EVT_RI  = 0;
    localparam int EVT_CPU = 1;
    localparam int EVT_SUB = 2;
    // instruction fields
    localparam int OPC_LSB = 26;
    localparam int RS_LSB  = 21;
    localparam int FN_LSB  = 0;
    // table geometry
    localparam int PRIM_DEPTH = 64;
    localparam int SUB_DEPTH  = 256;
    localparam int TSUB_BIT   = 8;
    localparam int ENTRY_W    = 10;
    typedef enum logic [3:0] {
        MK_IMPL, MK_EMPTY, MK_RESERVED, MK_CLASS, MK_HIGHER,
        MK_64ONLY, MK_FP64, MK_CORR, MK_CUSTOM
    } mark_t;
    typedef struct packed {
        logic       sub_rs;
        logic [1:0] sub_id;
        logic [1:0] cop_num;
        logic       cop_space;
        mark_t      mark;
    } entry_t;
    localparam entry_t ENTRY_RST = '{1'b0, 2'h0, 2'h0, 1'b0, MK_RESERVED};
    typedef enum logic [1:0] {OUT_EXEC, OUT_RI, OUT_CPU} outcome_t;
endpackage

// File: src/lookup_if.sv
// lookup and load path between the classifier and its marking tables
// assumes reads are combinational and loads land at pclk
`timescale 1ns/100ps
interface lookup_if;
    logic              wr_en;
    logic              wr_sub;
    logic [7:0]        wr_addr;
    opcls_pkg::entry_t wr_entry;
    logic [5:0]        prim_idx;
    logic [7:0]        sub_idx;
    opcls_pkg::entry_t prim_entry;
    opcls_pkg::entry_t sub_entry;
    modport owner (output wr_en, wr_sub, wr_addr, wr_entry, prim_idx, sub_idx,
                   input prim_entry, sub_entry);
    modport table_side (input wr_en, wr_sub, wr_addr, wr_entry, prim_idx, sub_idx,
                        output prim_entry, sub_entry);
endinterface

// File: src/mark_table.sv
// primary and sub-table encoding markings, loaded by software
// assumes the owner drives the lookup_if load strobe for one cycle per entry
`timescale 1ns/100ps
module mark_table (
    input wire logic     pclk,
    input wire logic     presetn,
    lookup_if.table_side lk
);
    opcls_pkg::entry_t prim_mem [opcls_pkg::PRIM_DEPTH];
    opcls_pkg::entry_t sub_mem  [opcls_pkg::SUB_DEPTH];

    // unloaded entries stay reserved, so an empty table traps everything
    genvar i;
    generate
        for (i = 0; i < opcls_pkg::PRIM_DEPTH; i++) begin : g_prim
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    prim_mem[i] <= opcls_pkg::ENTRY_RST;
                else if (lk.wr_en && !lk.wr_sub && lk.wr_addr == 8'(i))
                    prim_mem[i] <= lk.wr_entry;
            end
        end
        for (i = 0; i < opcls_pkg::SUB_DEPTH; i++) begin : g_sub
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    sub_mem[i] <= opcls_pkg::ENTRY_RST;
                else if (lk.wr_en && lk.wr_sub && lk.wr_addr == 8'(i))
                    sub_mem[i] <= lk.wr_entry;
            end
        end
    endgenerate

    assign lk.prim_entry = prim_mem[lk.prim_idx];
    assign lk.sub_entry  = sub_mem[lk.sub_idx];
endmodule

// File: src/event_irq.sv
// sticky event status, enable mask and level interrupt
// assumes set and clear pulses are synchronous to pclk
`timescale 1ns/100ps
module event_irq #(
    parameter int N = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    input  wire logic         en_wr,
    input  wire logic [N-1:0] en_data,
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);
    logic [N-1:0] status_next;
    logic [N-1:0] enable_next;
    logic         irq_next;

    always_comb begin
        // set wins over a clear in the same cycle
        status_next = (status & ~clr) | set;
        enable_next = en_wr ? en_data : enable;
        irq_next    = |(status_next & enable_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            enable <= '0;
            irq    <= 1'b0;
        end else begin
            status <= status_next;
            enable <= enable_next;
            irq    <= irq_next;
        end
    end
endmodule

// File: dv/fetch_stage_model.sv
// fetch stage model: hands one instruction word per requested cycle to the classifier
// assumes the bench raises req_valid just after a rising pclk edge
`timescale 1ns/100ps
module fetch_stage_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_word,
    output logic             fetch_valid,
    output logic [31:0]      fetch_word
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_valid <= 1'b0;
            fetch_word  <= 32'h00000000;
        end else begin
            fetch_valid <= req_valid;
            // idle word keeps changing so a decode of a stale word shows up
            fetch_word  <= req_valid ? req_word : ~fetch_word;
        end
    end
endmodule

// File: dv/illegal_opcode_classifier_props.sv
// port-level assertions for the opcode classifier
// assumes single pclk domain, presetn asynchronous active low
`timescale 1ns/100ps
module illegal_opcode_classifier_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fetch_valid,
    input wire logic [31:0] fetch_word,
    input wire logic        dec_valid,
    input wire logic [31:0] dec_word,
    input wire logic        dec_exec,
    input wire logic        dec_ri,
    input wire logic        dec_cpu,
    input wire logic [1:0]  dec_cop_num,
    input wire logic        irq
);
    one_outcome_a: assert property (@(posedge pclk) disable iff (!presetn)
        dec_valid |-> $onehot({dec_exec, dec_ri, dec_cpu})) else $error("outcome not one-hot");
    quiet_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        !dec_valid |-> !(dec_exec || dec_ri || dec_cpu)) else $error("flag without valid");
    decode_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_valid |=> dec_valid && dec_word == $past(fetch_word))
        else $error("decode not one cycle after fetch");
    no_spurious_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fetch_valid |=> !dec_valid && $stable(dec_word)) else $error("decode without fetch");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && $rose(penable) |-> !pready ##1 (pready && penable))
        else $error("apb answer not in second access cycle");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready longer than one cycle");
    err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && psel && penable) else $error("pslverr outside answer");
    idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h00000000) else $error("prdata not zero when idle");
endmodule
bind illegal_opcode_classifier illegal_opcode_classifier_props i_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .dec_valid(dec_valid),
    .dec_word(dec_word), .dec_exec(dec_exec), .dec_ri(dec_ri), .dec_cpu(dec_cpu),
    .dec_cop_num(dec_cop_num), .irq(irq));

// File: dv/illegal_opcode_classifier_test.sv
// self-checking bench: loads markings over apb, fetches words, checks outcomes
// assumes one wait state apb slave and a one-cycle decode
`timescale 1ns/100ps
module illegal_opcode_classifier_test;
    localparam logic [2:0] EX = 3'b100;
    localparam logic [2:0] RI = 3'b010;
    localparam logic [2:0] CU = 3'b001;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel, penable, pwrite, pslverr, pready, err;
    logic [31:0] pwdata, prdata, rd, last_fault;
    logic        req_valid, fetch_valid, dec_valid, dec_exec, dec_ri, dec_cpu, irq;
    logic [31:0] req_word, fetch_word, dec_word;
    logic [1:0]  dec_cop_num;
    int          miscompares, samples_checked, cycles, ri_n, cpu_n;

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    fetch_stage_model i_fetch (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
        .req_word(req_word), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
    illegal_opcode_classifier i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .dec_valid(dec_valid), .dec_word(dec_word),
        .dec_exec(dec_exec), .dec_ri(dec_ri), .dec_cpu(dec_cpu),
        .dec_cop_num(dec_cop_num), .irq(irq));

    task results;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one idle cycle after each transfer keeps psel from being driven twice in a step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no answer time assumed: a hung slave is caught by the cycle ceiling
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task fetch_chk(input logic [31:0] w, input logic [2:0] exp);
        req_valid <= 1'b1;
        req_word  <= w;
        @(posedge pclk);
        req_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        check("outcome", {29'h0, dec_exec, dec_ri, dec_cpu}, {29'h0, exp});
        check("dec_word", dec_word, w);
        if (exp == RI) ri_n++;
        if (exp == CU) cpu_n++;
        if (exp != EX) last_fault = w;
    endtask
    task run_case(input logic [11:0] ctrl, input opcls_pkg::mark_t mk, input logic cs,
                  input logic [1:0] cn, input logic [2:0] exp);
        opcls_pkg::entry_t e;
        e = '{1'b0, 2'h0, cn, cs, mk};
        apb(1'b1, opcls_pkg::CTRL_OFF, {20'h0, ctrl});
        apb(1'b1, opcls_pkg::TADDR_OFF, 32'h0000002A);
        apb(1'b1, opcls_pkg::TDATA_OFF, {22'h0, e});
        fetch_chk(32'hA8001234, exp);
        check("cop_num", {30'h0, dec_cop_num}, {30'h0, cn});
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            results;
        end
    end

    initial begin
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 8'h00;
        pwdata          = 32'h0;
        req_valid       = 1'b0;
        req_word        = 32'h0;
        cycles          = 0;
        last_fault      = 32'h0;
        miscompares     = 0;
        samples_checked = 0;
        ri_n            = 0;
        cpu_n           = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, opcls_pkg::CTRL_OFF, 32'h0);
        check("ctrl reset", rd, {20'h0, opcls_pkg::CTRL_RST});
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, opcls_pkg::CNT_OFF, 32'h0);
        run_case(12'h000, opcls_pkg::MK_RESERVED, 1'b0, 2'h0, RI);
        check("irq masked", {31'h0, irq}, 32'h0);
        run_case(12'h000, opcls_pkg::MK_RESERVED, 1'b1, 2'h1, CU);
        run_case(12'h200, opcls_pkg::MK_RESERVED, 1'b1, 2'h1, RI);
        run_case(12'h002, opcls_pkg::MK_EMPTY, 1'b0, 2'h0, RI);
        run_case(12'h000, opcls_pkg::MK_EMPTY, 1'b0, 2'h0, EX);
        run_case(12'h001, opcls_pkg::MK_HIGHER, 1'b0, 2'h0, RI);
        run_case(12'h000, opcls_pkg::MK_IMPL, 1'b0, 2'h0, EX);
        run_case(12'h004, opcls_pkg::MK_64ONLY, 1'b0, 2'h0, EX);
        run_case(12'h000, opcls_pkg::MK_64ONLY, 1'b0, 2'h0, RI);
        run_case(12'h000, opcls_pkg::MK_64ONLY, 1'b1, 2'h1, CU);
        run_case(12'h200, opcls_pkg::MK_64ONLY, 1'b1, 2'h1, RI);
        run_case(12'h004, opcls_pkg::MK_FP64, 1'b0, 2'h0, EX);
        run_case(12'h008, opcls_pkg::MK_FP64, 1'b0, 2'h0, RI);
        run_case(12'h009, opcls_pkg::MK_FP64, 1'b0, 2'h0, EX);
        run_case(12'h005, opcls_pkg::MK_FP64, 1'b0, 2'h0, RI);
        run_case(12'h001, opcls_pkg::MK_FP64, 1'b1, 2'h3, CU);
        run_case(12'h010, opcls_pkg::MK_CORR, 1'b0, 2'h0, EX);
        run_case(12'h000, opcls_pkg::MK_CORR, 1'b0, 2'h0, RI);
        run_case(12'h001, opcls_pkg::MK_CORR, 1'b0, 2'h0, EX);
        run_case(12'h021, opcls_pkg::MK_CORR, 1'b0, 2'h0, EX);
        run_case(12'h000, opcls_pkg::MK_CUSTOM, 1'b0, 2'h0, RI);
        run_case(12'h400, opcls_pkg::MK_CUSTOM, 1'b1, 2'h2, RI);
        run_case(12'h000, opcls_pkg::MK_CUSTOM, 1'b1, 2'h2, CU);
        apb(1'b1, opcls_pkg::INTEN_OFF, 32'h7);
        @(posedge pclk);
        check("irq enabled", {31'h0, irq}, 32'h1);
        apb(1'b0, opcls_pkg::STAT_OFF, 32'h0);
        check("status", rd, 32'h3);
        // class opcode 0x11 decodes through sub-table 1 by function field
        apb(1'b1, opcls_pkg::TADDR_OFF, 32'h11);
        apb(1'b1, opcls_pkg::TDATA_OFF, {22'h0, 1'b0, 2'h1, 2'h0, 1'b0, opcls_pkg::MK_CLASS});
        apb(1'b1, opcls_pkg::TADDR_OFF, 32'h145);
        apb(1'b1, opcls_pkg::TDATA_OFF, {28'h0, opcls_pkg::MK_IMPL});
        apb(1'b1, opcls_pkg::TDATA_OFF, {28'h0, opcls_pkg::MK_CLASS});
        fetch_chk(32'h44000005, EX);
        fetch_chk(32'h44000006, RI);
        fetch_chk(32'h44000007, RI);
        apb(1'b0, opcls_pkg::STAT_OFF, 32'h0);
        check("status nested", rd, 32'h7);
        // class opcode 0x12 decodes through sub-table 2 by rs field; fn path would trap
        apb(1'b1, opcls_pkg::TADDR_OFF, 32'h12);
        apb(1'b1, opcls_pkg::TDATA_OFF, {22'h0, 1'b1, 2'h2, 2'h0, 1'b0, opcls_pkg::MK_CLASS});
        apb(1'b1, opcls_pkg::TADDR_OFF, 32'h183);
        apb(1'b1, opcls_pkg::TDATA_OFF, {28'h0, opcls_pkg::MK_IMPL});
        fetch_chk(32'h48600000, EX);
        req_valid <= 1'b1;
        req_word  <= 32'h44000005;
        @(posedge pclk);
        req_word <= 32'h44000006;
        @(posedge pclk);
        req_valid <= 1'b0;
        @(posedge pclk);
        check("b2b first", {29'h0, dec_exec, dec_ri, dec_cpu}, {29'h0, EX});
        @(posedge pclk);
        check("b2b second", {29'h0, dec_exec, dec_ri, dec_cpu}, {29'h0, RI});
        ri_n++;
        last_fault = 32'h44000006;
        apb(1'b0, opcls_pkg::FWORD_OFF, 32'h0);
        check("fault word", rd, last_fault);
        apb(1'b0, opcls_pkg::CNT_OFF, 32'h0);
        check("counts", rd, {cpu_n[15:0], ri_n[15:0]});
        apb(1'b1, opcls_pkg::INTCLR_OFF, 32'h7);
        apb(1'b0, opcls_pkg::STAT_OFF, 32'h0);
        check("status cleared", rd, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        results;
    end
endmodule
